/* shared/twfc_cfg.svh */
`ifndef TWFC_CFG_SVH
`define TWFC_CFG_SVH
`define TWFC_CLK_MHZ          100
`define TWFC_TIMEOUT_US       100
`define TWFC_TIMEOUT_CYC      (`TWFC_TIMEOUT_US * `TWFC_CLK_MHZ)
`define TWFC_CNT_W            16
`define TWFC_STS_STOPADDR_BIT 6
`define TWFC_STS_COLL_BIT     3
`define TWFC_CMD_NONE         2'h0
`define TWFC_CMD_RESP         2'h3
`define TWFC_ADDR_BITS        7
`define TWFC_BIT_LAST         4'h7
`define TWFC_BIT_ACK          4'h8
`endif

/* shared/twfc_pkg.sv */
package twfc_pkg;
	typedef enum logic [1:0] {
		TWFC_BUS_UNKNOWN = 2'b00,
		TWFC_BUS_IDLE    = 2'b01,
		TWFC_BUS_BUSY    = 2'b11
	} twfc_bus_e;

	// One toggle per link event kind
	typedef struct packed {
		logic start;
		logic rstart;
		logic stop;
		logic addr;
		logic data;
	} twfc_evt_s;
endpackage

/* hdl/twfc_link_front.sv */
`timescale 1ns/100ps
`include "twfc_cfg.svh"
module twfc_link_front #(
	parameter int ADDR_W = `TWFC_ADDR_BITS
) (
	input  wire logic              linkClk,
	input  wire logic              rst,
	input  wire logic              sclIn,
	input  wire logic              sdaIn,
	input  wire logic [ADDR_W-1:0] ownAddr,
	output twfc_pkg::twfc_evt_s    evtTgl
);
	if (ADDR_W != 7) begin : g_chk
		$error("twfc_link_front: only 7-bit addressing is served");
	end

	logic              rstS1, linkRst;
	logic              sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD;
	logic [ADDR_W-1:0] addrS1, addrS2;
	logic              busy_reg, busy_next;
	logic              addrPhase_reg, addrPhase_next;
	logic              matched_reg, matched_next;
	logic [3:0]        bitCnt_reg, bitCnt_next;
	logic [ADDR_W-1:0] shift_reg, shift_next;
	twfc_pkg::twfc_evt_s tgl_reg, tgl_next;
	logic              startC, stopC, sclRise;

	// Reset, pins and quasi-static address all cross on two flops
	always_ff @(posedge linkClk) begin
		rstS1   <= rst;
		linkRst <= rstS1;
		sclS1   <= sclIn;
		sclS2   <= sclS1;
		sclD    <= sclS2;
		sdaS1   <= sdaIn;
		sdaS2   <= sdaS1;
		sdaD    <= sdaS2;
		addrS1  <= ownAddr;
		addrS2  <= addrS1;
	end

	assign startC  = sclS2 & sclD & sdaD & ~sdaS2;
	assign stopC   = sclS2 & sclD & ~sdaD & sdaS2;
	assign sclRise = sclS2 & ~sclD;

	always_comb begin
		busy_next      = busy_reg;
		addrPhase_next = addrPhase_reg;
		matched_next   = matched_reg;
		bitCnt_next    = bitCnt_reg;
		shift_next     = shift_reg;
		tgl_next       = tgl_reg;
		if (startC) begin
			if (busy_reg) begin
				tgl_next.rstart = ~tgl_reg.rstart;
			end else begin
				tgl_next.start = ~tgl_reg.start;
			end
			busy_next      = 1'b1;
			addrPhase_next = 1'b1;
			matched_next   = 1'b0;
			bitCnt_next    = 4'h0;
		end else if (stopC) begin
			tgl_next.stop  = ~tgl_reg.stop;
			busy_next      = 1'b0;
			addrPhase_next = 1'b0;
			matched_next   = 1'b0;
		end else if (sclRise && busy_reg) begin
			if (bitCnt_reg == `TWFC_BIT_ACK) begin
				bitCnt_next = 4'h0;
			end else begin
				shift_next  = {shift_reg[ADDR_W-2:0], sdaS2};
				bitCnt_next = bitCnt_reg + 4'h1;
				if (bitCnt_reg == `TWFC_BIT_LAST) begin
					// Eighth bit is R/W; the seven before it are the address
					if (addrPhase_reg) begin
						addrPhase_next = 1'b0;
						if (shift_reg == addrS2) begin
							matched_next  = 1'b1;
							tgl_next.addr = ~tgl_reg.addr;
						end
					end else if (matched_reg) begin
						tgl_next.data = ~tgl_reg.data;
					end
				end
			end
		end
	end

	always_ff @(posedge linkClk) begin
		if (linkRst) begin
			busy_reg      <= 1'b0;
			addrPhase_reg <= 1'b0;
			matched_reg   <= 1'b0;
			bitCnt_reg    <= 4'h0;
			shift_reg     <= '0;
			tgl_reg       <= '0;
		end else begin
			busy_reg      <= busy_next;
			addrPhase_reg <= addrPhase_next;
			matched_reg   <= matched_next;
			bitCnt_reg    <= bitCnt_next;
			shift_reg     <= shift_next;
			tgl_reg       <= tgl_next;
		end
	end

	assign evtTgl = tgl_reg;
endmodule

/* hdl/twfc_flag_core.sv */
// What this block does
// - Transmit collision flag clears on START, but stays set on repeated START.
// - Clear racing a new-address set keeps clock stretch held and SCL low.
// - Timeout expiring with START in the same cycle drops that transaction.
// - Response command 0b11 clears the data flag one cycle late.
// - Data hold time option is a single bit.
// - Second two-wire unit is absent; writes enabling it do nothing.
`timescale 1ns/100ps
`include "twfc_cfg.svh"
module twfc_flag_core #(
	parameter int ADDR_W         = `TWFC_ADDR_BITS,
	parameter int CNT_W          = `TWFC_CNT_W,
	parameter int TIMEOUT_CYCLES = `TWFC_TIMEOUT_CYC
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              linkClk,
	input  wire logic              sclIn,
	input  wire logic              sdaIn,
	input  wire logic [ADDR_W-1:0] ownAddr,
	input  wire logic              timeoutEn,
	input  wire logic              collisionEvt,
	input  wire logic              slvStatusWr,
	input  wire logic [7:0]        slvStatusWrData,
	input  wire logic              cmdValid,
	input  wire logic [1:0]        cmdCode,
	input  wire logic              cfgWr,
	input  wire logic              cfgHoldSel,
	output logic                   stopAddrIrqFlag,
	output logic                   dataIrqFlag,
	output logic                   txCollisionFlag,
	output logic                   sclStretchHold,
	output twfc_pkg::twfc_bus_e    busState,
	output logic                   sclLineLow,
	output logic                   transDropped,
	output logic                   dataHoldTimeSel,
	output logic                   porteUnitEnabled,
	output logic                   sclOut,
	output logic                   sclOeN
);
	if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (2 ** CNT_W)) begin : g_chk
		$error("twfc_flag_core: TIMEOUT_CYCLES does not fit the counter");
	end

	localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TIMEOUT_CYCLES - 1);

	twfc_pkg::twfc_evt_s evtTgl, tglS1, tglS2, tglS3, evt;
	logic                sclS1, sclS2;

	twfc_link_front #(
		.ADDR_W (ADDR_W)
	) u_front (
		.linkClk (linkClk),
		.rst     (rst),
		.sclIn   (sclIn),
		.sdaIn   (sdaIn),
		.ownAddr (ownAddr),
		.evtTgl  (evtTgl)
	);

	// Toggle crossing: edge detect reads only the second and third stages
	always_ff @(posedge clk) begin
		if (rst) begin
			tglS1 <= '0;
			tglS2 <= '0;
			tglS3 <= '0;
			sclS1 <= 1'b1;
			sclS2 <= 1'b1;
		end else begin
			tglS1 <= evtTgl;
			tglS2 <= tglS1;
			tglS3 <= tglS2;
			sclS1 <= sclIn;
			sclS2 <= sclS1;
		end
	end

	assign evt = tglS2 ^ tglS3;

	logic                stopAddr_reg, stopAddr_next;
	logic                data_reg, data_next;
	logic                dataClrPend_reg, dataClrPend_next;
	logic                coll_reg, coll_next;
	logic                hold_reg, hold_next;
	twfc_pkg::twfc_bus_e bus_reg, bus_next;
	logic [CNT_W-1:0]    toCnt_reg, toCnt_next;
	logic                drop_reg, drop_next;
	logic                holdSel_reg, holdSel_next;
	logic                porteEn_reg, porteEn_next;
	logic                sclLow_reg, sclOeN_reg, sclOut_reg;
	logic                anyStart, anyEvt, expire, addrOk, dataOk;
	logic                clrStopAddr, clrColl, respCmd, otherCmd;

	assign anyStart    = evt.start | evt.rstart;
	assign anyEvt      = anyStart | evt.stop | evt.addr | evt.data;
	assign expire      = timeoutEn && (bus_reg == twfc_pkg::TWFC_BUS_BUSY)
	                     && (toCnt_reg == TO_LAST);
	assign addrOk      = evt.addr & ~drop_reg;
	assign dataOk      = evt.data & ~drop_reg;
	assign clrStopAddr = slvStatusWr & slvStatusWrData[`TWFC_STS_STOPADDR_BIT];
	assign clrColl     = slvStatusWr & slvStatusWrData[`TWFC_STS_COLL_BIT];
	assign respCmd     = cmdValid & (cmdCode == `TWFC_CMD_RESP);
	assign otherCmd    = cmdValid & (cmdCode != `TWFC_CMD_RESP)
	                     & (cmdCode != `TWFC_CMD_NONE);

	// Bus state and timeout
	always_comb begin
		bus_next   = bus_reg;
		drop_next  = drop_reg;
		toCnt_next = toCnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		if (!timeoutEn || bus_reg != twfc_pkg::TWFC_BUS_BUSY || anyEvt) begin
			toCnt_next = '0;
		end
		if (expire) begin
			bus_next  = twfc_pkg::TWFC_BUS_IDLE;
			drop_next = anyStart;
		end else if (anyStart) begin
			bus_next  = twfc_pkg::TWFC_BUS_BUSY;
			drop_next = 1'b0;
		end else if (evt.stop) begin
			bus_next  = twfc_pkg::TWFC_BUS_IDLE;
			drop_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_reg   <= twfc_pkg::TWFC_BUS_UNKNOWN;
			drop_reg  <= 1'b0;
			toCnt_reg <= '0;
		end else begin
			bus_reg   <= bus_next;
			drop_reg  <= drop_next;
			toCnt_reg <= toCnt_next;
		end
	end

	// Flags, stretch hold and configuration
	always_comb begin
		stopAddr_next = addrOk | evt.stop | (stopAddr_reg & ~clrStopAddr);
		// A clear in the same cycle as a set does not release the hold
		hold_next = addrOk | (hold_reg & ~((clrStopAddr & ~addrOk & ~evt.stop)
		            | respCmd | otherCmd));
		// Response command only schedules the clear
		dataClrPend_next = respCmd;
		data_next = dataOk | (data_reg & ~dataClrPend_reg & ~otherCmd);
		// Repeated START leaves the collision flag alone
		coll_next = collisionEvt | (coll_reg & ~(evt.start | clrColl));
		holdSel_next = cfgWr ? cfgHoldSel : holdSel_reg;
		porteEn_next = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stopAddr_reg    <= 1'b0;
			hold_reg        <= 1'b0;
			dataClrPend_reg <= 1'b0;
			data_reg        <= 1'b0;
			coll_reg        <= 1'b0;
			holdSel_reg     <= 1'b0;
			porteEn_reg     <= 1'b0;
			sclLow_reg      <= 1'b0;
			sclOeN_reg      <= 1'b1;
			sclOut_reg      <= 1'b0;
		end else begin
			stopAddr_reg    <= stopAddr_next;
			hold_reg        <= hold_next;
			dataClrPend_reg <= dataClrPend_next;
			data_reg        <= data_next;
			coll_reg        <= coll_next;
			holdSel_reg     <= holdSel_next;
			porteEn_reg     <= porteEn_next;
			sclLow_reg      <= ~sclS2;
			sclOeN_reg      <= ~hold_next;
			sclOut_reg      <= 1'b0;
		end
	end

	assign stopAddrIrqFlag  = stopAddr_reg;
	assign dataIrqFlag      = data_reg;
	assign txCollisionFlag  = coll_reg;
	assign sclStretchHold   = hold_reg;
	assign busState         = bus_reg;
	assign sclLineLow       = sclLow_reg;
	assign transDropped     = drop_reg;
	assign dataHoldTimeSel  = holdSel_reg;
	assign porteUnitEnabled = porteEn_reg;
	assign sclOut           = sclOut_reg;
	assign sclOeN           = sclOeN_reg;

	coll_start_clr_a: assert property (@(posedge clk) disable iff (rst)
		evt.start && !collisionEvt |=> !txCollisionFlag)
		else $error("collision flag not cleared by START");

	coll_rstart_keep_a: assert property (@(posedge clk) disable iff (rst)
		evt.rstart && !evt.start && txCollisionFlag && !clrColl |=> txCollisionFlag)
		else $error("collision flag cleared by repeated START");

	race_hold_a: assert property (@(posedge clk) disable iff (rst)
		addrOk && clrStopAddr |=> stopAddrIrqFlag && sclStretchHold && !sclOeN)
		else $error("racing clear released the stretch hold");

	scl_drive_a: assert property (@(posedge clk) disable iff (rst)
		sclOeN == !sclStretchHold)
		else $error("SCL drive does not follow stretch hold");

	drop_start_a: assert property (@(posedge clk) disable iff (rst)
		expire && evt.start |=> transDropped && busState == twfc_pkg::TWFC_BUS_IDLE)
		else $error("START at timeout not dropped");

	drop_noaddr_a: assert property (@(posedge clk) disable iff (rst)
		transDropped && evt.addr && !evt.stop && !stopAddrIrqFlag |=> !stopAddrIrqFlag)
		else $error("dropped transaction raised address flag");

	dif_delay_a: assert property (@(posedge clk) disable iff (rst)
		respCmd && dataIrqFlag && !dataClrPend_reg
		|=> dataIrqFlag ##1 (!dataIrqFlag || $past(dataOk)))
		else $error("data flag not cleared one cycle after response");

	hold_cfg_a: assert property (@(posedge clk) disable iff (rst)
		cfgWr |=> dataHoldTimeSel == $past(cfgHoldSel))
		else $error("hold time option not stored");

	porte_off_a: assert property (@(posedge clk) disable iff (rst)
		!porteUnitEnabled)
		else $error("absent unit reports enabled");

	sa_w1c_a: assert property (@(posedge clk) disable iff (rst)
		slvStatusWr && !slvStatusWrData[`TWFC_STS_STOPADDR_BIT] && stopAddrIrqFlag
		|=> stopAddrIrqFlag)
		else $error("writing zero cleared stop/address flag");

	// Set and clear priorities of the flags, bus state and hold time option
	coll_set_a: assert property (@(posedge clk) disable iff (rst)
		collisionEvt |=> txCollisionFlag)
		else $error("collision event did not set the flag");

	coll_clr_a: assert property (@(posedge clk) disable iff (rst)
		clrColl && !collisionEvt |=> !txCollisionFlag)
		else $error("collision flag not cleared by write");

	sa_set_a: assert property (@(posedge clk) disable iff (rst)
		addrOk || evt.stop |=> stopAddrIrqFlag)
		else $error("stop/address flag not set");

	sa_clr_a: assert property (@(posedge clk) disable iff (rst)
		clrStopAddr && !addrOk && !evt.stop |=> !stopAddrIrqFlag)
		else $error("writing one did not clear stop/address flag");

	hold_set_a: assert property (@(posedge clk) disable iff (rst)
		addrOk |=> sclStretchHold && !sclOeN)
		else $error("address match did not hold SCL");

	hold_rel_a: assert property (@(posedge clk) disable iff (rst)
		respCmd && !addrOk |=> !sclStretchHold)
		else $error("command did not release stretch hold");

	scl_out_a: assert property (@(posedge clk) disable iff (rst)
		!sclOut)
		else $error("SCL driven high");

	dif_set_a: assert property (@(posedge clk) disable iff (rst)
		dataOk |=> dataIrqFlag)
		else $error("data byte did not set data flag");

	dif_pend_a: assert property (@(posedge clk) disable iff (rst)
		respCmd |=> dataClrPend_reg)
		else $error("response command did not schedule the clear");

	dif_other_a: assert property (@(posedge clk) disable iff (rst)
		otherCmd && !dataOk |=> !dataIrqFlag)
		else $error("other command did not clear data flag at once");

	start_busy_a: assert property (@(posedge clk) disable iff (rst)
		anyStart && !expire |=> busState == twfc_pkg::TWFC_BUS_BUSY)
		else $error("START did not make the bus busy");

	stop_idle_a: assert property (@(posedge clk) disable iff (rst)
		evt.stop && !anyStart |=> busState == twfc_pkg::TWFC_BUS_IDLE)
		else $error("STOP did not make the bus idle");

	drop_idle_a: assert property (@(posedge clk) disable iff (rst)
		expire |=> busState == twfc_pkg::TWFC_BUS_IDLE && transDropped == $past(anyStart))
		else $error("timeout expiry handled wrongly");

	drop_nodata_a: assert property (@(posedge clk) disable iff (rst)
		transDropped && evt.data && !dataIrqFlag |=> !dataIrqFlag)
		else $error("dropped transaction raised data flag");

	hold_keep_a: assert property (@(posedge clk) disable iff (rst)
		!cfgWr |=> $stable(dataHoldTimeSel))
		else $error("hold time option changed without a write");
endmodule

/* dv/twfc_i2c_master.sv */
`timescale 1ns/100ps
module twfc_i2c_master #(
	parameter int HALF_NS = 150
) (
	input  wire logic sclOeN,
	input  wire logic sclOut,
	output logic      sclLine,
	output logic      sdaLine
);
	logic sclDrv = 1'b1;
	logic sdaDrv = 1'b1;
	// Open-drain wires: released lines float high through the pull-ups
	assign sclLine = sclDrv & (sclOeN | sclOut);
	assign sdaLine = sdaDrv;
	task automatic sclPulse();
		#HALF_NS sclDrv = 1'b1;
		// Slave clock stretching is honoured
		wait (sclLine === 1'b1);
		#HALF_NS sclDrv = 1'b0;
	endtask
	task automatic start();
		#(HALF_NS / 3) sdaDrv = 1'b1;
		#HALF_NS sclDrv = 1'b1;
		#HALF_NS sdaDrv = 1'b0;
		#HALF_NS sclDrv = 1'b0;
	endtask
	task automatic stop();
		#(HALF_NS / 3) sdaDrv = 1'b0;
		#HALF_NS sclDrv = 1'b1;
		#HALF_NS sdaDrv = 1'b1;
	endtask
	task automatic sendByte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			#(HALF_NS / 3) sdaDrv = b[i];
			sclPulse();
		end
		#(HALF_NS / 3) sdaDrv = 1'b1;
		sclPulse();
	endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	typedef struct packed {
		logic [9:0] m;
		logic [9:0] v;
	} twfc_exp_s;
	localparam int TO = 40;
	localparam logic [9:0] SA = 10'h200, DA = 10'h100, CO = 10'h080, HO = 10'h040;
	localparam logic [9:0] OE = 10'h020, BS = 10'h018, TD = 10'h004, HS = 10'h002;
	logic clk = 1'b0, linkClk = 1'b0, rst = 1'b1;
	logic sclIn, sdaIn, holdBit;
	logic [6:0] ownAddr = 7'h00;
	logic timeoutEn = 1'b0, collisionEvt = 1'b0, slvStatusWr = 1'b0;
	logic [7:0] slvStatusWrData = 8'h00;
	logic cmdValid = 1'b0, cfgWr = 1'b0, cfgHoldSel = 1'b0;
	logic [1:0] cmdCode = 2'h0;
	logic stopAddrIrqFlag, dataIrqFlag, txCollisionFlag, sclStretchHold, transDropped;
	logic dataHoldTimeSel, porteUnitEnabled, sclOut, sclOeN, sclLineLow;
	twfc_pkg::twfc_bus_e busState;
	twfc_exp_s expQ[$];
	int error_cnt = 0, n_tests = 0;
	wire [9:0] sts = {stopAddrIrqFlag, dataIrqFlag, txCollisionFlag, sclStretchHold,
		sclOeN, busState, transDropped, dataHoldTimeSel, porteUnitEnabled};
	twfc_flag_core #(.TIMEOUT_CYCLES(TO)) u_twfc_flag_core (
		.clk(clk), .rst(rst), .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn),
		.ownAddr(ownAddr), .timeoutEn(timeoutEn), .collisionEvt(collisionEvt),
		.slvStatusWr(slvStatusWr), .slvStatusWrData(slvStatusWrData),
		.cmdValid(cmdValid), .cmdCode(cmdCode), .cfgWr(cfgWr), .cfgHoldSel(cfgHoldSel),
		.stopAddrIrqFlag(stopAddrIrqFlag), .dataIrqFlag(dataIrqFlag),
		.txCollisionFlag(txCollisionFlag), .sclStretchHold(sclStretchHold),
		.busState(busState), .sclLineLow(sclLineLow), .transDropped(transDropped),
		.dataHoldTimeSel(dataHoldTimeSel), .porteUnitEnabled(porteUnitEnabled),
		.sclOut(sclOut), .sclOeN(sclOeN));
	twfc_i2c_master u_twfc_i2c_master (
		.sclOeN(sclOeN), .sclOut(sclOut), .sclLine(sclIn), .sdaLine(sdaIn));
	initial forever #5 clk = ~clk;
	initial begin
		#7;
		forever #15 linkClk = ~linkClk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [9:0] m, input logic [9:0] v);
		expQ.push_back('{m, v});
	endtask
	task automatic cmpSts(input twfc_exp_s e);
		n_tests++;
		if ((sts & e.m) !== (e.v & e.m)) begin
			error_cnt++;
			$display("FAIL %0t status %h expected %h mask %h", $time, sts, e.v, e.m);
		end
	endtask
	task automatic waitBit(input int k);
		for (int i = 0; i < 3000 && sts[k] !== 1'b1; i++) @(negedge clk);
	endtask
	task automatic wrSts(input logic [7:0] d);
		slvStatusWrData = d;
		slvStatusWr = 1'b1;
		cyc(1);
		slvStatusWr = 1'b0;
	endtask
	task automatic cmd(input logic [1:0] c);
		cmdCode = c;
		cmdValid = 1'b1;
		cyc(1);
		cmdValid = 1'b0;
	endtask
	task automatic pulseCol();
		collisionEvt = 1'b1;
		cyc(1);
		collisionEvt = 1'b0;
		chk(CO, CO);
	endtask
	task automatic addrPhase(input logic [1:0] c);
		fork u_twfc_i2c_master.sendByte({ownAddr, 1'b0}); join_none
		waitBit(9);
		chk(SA | HO | OE, SA | HO);
		// Stop/address bit is written as zero, so the flag is left alone
		wrSts(8'h00);
		chk(SA, SA);
		cmd(c);
		chk(HO | OE, OE);
		wait fork;
	endtask
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		twfc_exp_s e;
		forever begin
			wait (expQ.size() > 0);
			e = expQ.pop_front();
			cmpSts(e);
		end
	end
	initial begin
		#500_000;
		error_cnt++;
		results();
	end
	initial begin
		void'($urandom(32'h9875));
		ownAddr = 7'($urandom);
		cyc(20);
		rst = 1'b0;
		chk(10'h3ff, OE);
		cyc(10);
		for (int i = 0; i < 4; i++) begin
			holdBit = 1'($urandom);
			cfgHoldSel = holdBit;
			cfgWr = 1'b1;
			cyc(1);
			cfgWr = 1'b0;
			chk(HS | 10'h001, {8'h00, holdBit, 1'b0});
		end
		pulseCol();
		u_twfc_i2c_master.start();
		cyc(20);
		chk(CO | BS, BS);
		pulseCol();
		addrPhase(2'h1);
		// Bus is busy: clear only once SCL is seen low
		while (sclLineLow !== 1'b1) cyc(1);
		wrSts(8'h40);
		chk(SA, 10'h000);
		fork u_twfc_i2c_master.sendByte(8'($urandom)); join_none
		waitBit(8);
		cmd(2'h3);
		chk(DA, DA);
		cyc(1);
		chk(DA, 10'h000);
		wait fork;
		u_twfc_i2c_master.start();
		cyc(20);
		chk(CO, CO);
		addrPhase(2'h2);
		wrSts(8'h08);
		chk(CO, 10'h000);
		u_twfc_i2c_master.stop();
		cyc(20);
		chk(SA | BS, SA | 10'h008);
		wrSts(8'h40);
		chk(SA, 10'h000);
		u_twfc_i2c_master.start();
		fork u_twfc_i2c_master.sendByte({ownAddr, 1'b0}); join_none
		// Clear held every cycle so one lands on the address set
		slvStatusWrData = 8'h40;
		slvStatusWr = 1'b1;
		waitBit(9);
		slvStatusWr = 1'b0;
		cyc(5);
		chk(SA | HO | OE, SA | HO);
		cmd(2'h1);
		wait fork;
		u_twfc_i2c_master.stop();
		cyc(20);
		wrSts(8'h40);
		timeoutEn = 1'b1;
		u_twfc_i2c_master.start();
		cyc(12);
		chk(BS | TD, BS);
		cyc(TO);
		chk(BS | TD, 10'h008);
		u_twfc_i2c_master.stop();
		timeoutEn = 1'b0;
		cyc(20);
		wait (expQ.size() == 0);
		results();
	end
endmodule
